// ==== rtl/acr_context_top.sv ====
`timescale 1ns/1ns
`default_nettype none

module acr_range_cmp #(
  parameter int W = 24
) (
  input wire logic [W-1:0] addr,
  input wire logic [W-1:0] upper,
  input wire logic [W-1:0] lower,
  output logic upper_eq,
  output logic in_range,
  output logic lower_eq
);
  if (W <= acr_pkg::MASK_HI_BITS + 1) begin : g_bad_width
    $error("acr_range_cmp: width too small for the address mask");
  end

  assign upper_eq = (addr == upper);
  assign lower_eq = (addr == lower);
  assign in_range = (addr >= lower) && (addr <= upper);
endmodule : acr_range_cmp

module acr_context_top (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic ANALYSIS_CLOCK_N,
  input wire acr_pkg::acr_emu_t EMU,
  output acr_pkg::acr_gate_t COUNT_EN,
  output logic [acr_pkg::NCMP-1:0] COMP_RESULT,
  output logic [1:0] QUALIFIER
);
  import acr_pkg::*;

  if (PH4_CYC >= PH5_CYC || PH5_CYC >= ACQ_MIN_CYC) begin : g_bad_timing
    $error("acr_context_top: phase strobes must fall inside one bus state");
  end

  acr_state_t s_q;
  acr_state_t s_d;

  // ----------------------------------------
  // Address masking and comparators
  // ----------------------------------------
  logic [EA_W-1:0] masked_addr;
  logic [NCMP-1:0] comp_live;
  logic [NCMP-1:0] comp_src;
  logic [1:0] qual_live;

  always_comb begin
    masked_addr = s_q.acq.addr;
    if (s_q.mask[MASK_LSB_BIT]) begin
      masked_addr[0] = 1'b0;
    end
    if (s_q.mask[MASK_HI_BIT]) begin
      masked_addr[EA_W-1 -: MASK_HI_BITS] = '0;
    end
  end

  // Bit order per range: upper, in range, lower
  for (genvar r = 0; r < 2; r++) begin : g_cmp
    acr_range_cmp #(
      .W(EA_W)
    ) u_cmp (
      .addr(masked_addr),
      .upper(s_q.bound[r][0]),
      .lower(s_q.bound[r][1]),
      .upper_eq(comp_live[r*3]),
      .in_range(comp_live[r*3+1]),
      .lower_eq(comp_live[r*3+2])
    );
  end

  // Self-test lets software stand in for the comparators
  assign comp_src = s_q.test[TEST_FORCE_BIT] ? s_q.force_bits[NCMP-1:0] : comp_live;
  assign qual_live = s_q.qmem[s_q.acq.status];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  logic edge_seen;
  logic run;
  logic ph4;
  logic ph5;
  logic tick;
  logic hit;
  logic [1:0] qsel;
  acr_mode_t mode;
  logic bnd_hit;
  logic [1:0] bnd_byte;

  always_comb begin
    s_d = s_q;
    run = s_q.ctrl[CTRL_RUN_BIT];
    edge_seen = ANALYSIS_CLOCK_N & ~s_q.anal_q;
    ph4 = s_q.dline[PH4_CYC-1];
    ph5 = s_q.dline[PH5_CYC-1];
    tick = (s_q.tdiv == TRES_CYC - 8'h01);
    qsel = s_q.mode[MODE_QSEL_LSB +: 2];
    mode = acr_mode_t'(s_q.mode[MODE_SEL_LSB +: 2]);
    hit = (qsel == 2'h0) | (|(qual_live & qsel));
    bnd_hit = (ADDR <= OFS_BOUND_LAST) && (ADDR[1:0] != BND_HOLE);
    bnd_byte = ADDR[1:0];
    s_d.rdata = '0;
    s_d.cnt = '0;

    // Acquisition pipeline
    s_d.anal_q = ANALYSIS_CLOCK_N;
    s_d.dline = {s_q.dline[PH5_CYC-2:0], edge_seen & run};
    if (edge_seen && run) begin
      s_d.acq = EMU;
    end

    // Phase 4: results latched, state machine steps
    if (ph4) begin
      s_d.comp = comp_src;
      s_d.qual = qual_live;
      s_d.sm_out = '0;
      case (mode)
        MD_RANGE: begin
          s_d.sm_out.event_en = comp_src[1] & hit;
          s_d.sm_out.time_en = comp_src[1] & hit;
          s_d.sm = (comp_src[1] & hit) ? ST_ACTIVE : ST_IDLE;
        end
        MD_WINDOW: begin
          case (s_q.sm)
            ST_ACTIVE: begin
              if (comp_src[4] & hit) begin
                s_d.sm = ST_IDLE;
              end else begin
                s_d.sm_out.event_en = hit;
                s_d.sm_out.time_en = 1'b1;
              end
            end
            default: begin
              if (comp_src[1] & hit) begin
                s_d.sm = ST_ACTIVE;
                s_d.sm_out.event_en = 1'b1;
                s_d.sm_out.time_en = 1'b1;
              end else begin
                s_d.sm = ST_IDLE;
              end
            end
          endcase
        end
        MD_SEQ: begin
          case (s_q.sm)
            ST_ARMED: begin
              s_d.sm_out.time_en = 1'b1;
              if (comp_src[0] & hit) begin
                s_d.sm = ST_IDLE;
                s_d.sm_out.seq_en = 1'b1;
                s_d.sm_out.event_en = 1'b1;
              end else if (comp_src[4] & hit) begin
                // Range B hit aborts a pass in progress
                s_d.sm = ST_IDLE;
              end
            end
            default: begin
              s_d.sm = (comp_src[2] & hit) ? ST_ARMED : ST_IDLE;
            end
          endcase
        end
        default: begin
          s_d.sm = ST_IDLE;
        end
      endcase
    end

    // Phase 5: event and sequence counters fire
    if (ph5) begin
      s_d.cnt.event_en = s_q.sm_out.event_en & run;
      s_d.cnt.seq_en = s_q.sm_out.seq_en & run;
    end

    // Time base runs free so gating never skews resolution
    s_d.tdiv = tick ? 8'h00 : s_q.tdiv + 8'h01;
    s_d.cnt.time_en = tick & s_q.sm_out.time_en & run;

    // ----------------------------------------
    // Register writes
    // ----------------------------------------
    if (WR) begin
      if (bnd_hit) begin
        s_d.bound[ADDR[BND_RANGE_BIT]][ADDR[BND_SEL_BIT]][bnd_byte] = WDATA;
      end
      case (ADDR)
        OFS_MASK: s_d.mask = WDATA;
        OFS_MODE: begin
          s_d.mode = WDATA;
          s_d.sm = ST_IDLE;
          s_d.sm_out = '0;
        end
        OFS_TEST: s_d.test = WDATA;
        OFS_FORCE: s_d.force_bits = WDATA;
        OFS_QPTR: s_d.qptr = WDATA;
        OFS_QDATA: begin
          s_d.qmem[s_q.qptr] = WDATA[1:0];
          s_d.qptr = s_q.qptr + 8'h01;
        end
        OFS_CTRL: s_d.ctrl = WDATA;
        default: begin
        end
      endcase
    end

    // ----------------------------------------
    // Register reads
    // ----------------------------------------
    if (RD) begin
      if (bnd_hit) begin
        s_d.rdata = s_q.bound[ADDR[BND_RANGE_BIT]][ADDR[BND_SEL_BIT]][bnd_byte];
      end
      case (ADDR)
        OFS_MASK: s_d.rdata = s_q.mask;
        OFS_MODE: s_d.rdata = s_q.mode;
        OFS_TEST: s_d.rdata = s_q.test;
        OFS_FORCE: s_d.rdata = s_q.force_bits;
        OFS_QPTR: s_d.rdata = s_q.qptr;
        OFS_QDATA: s_d.rdata = {6'h00, s_q.qmem[s_q.qptr]};
        OFS_CTRL: s_d.rdata = s_q.ctrl;
        OFS_COMP_RD: s_d.rdata = {2'h0, s_q.comp};
        OFS_CTX_RD: s_d.rdata = {s_q.qual, s_q.sm_out, 1'b0, s_q.sm};
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      s_q <= '0;
      s_q.mask <= MASK_RST;
      s_q.mode <= MODE_RST;
      s_q.test <= TEST_RST;
      s_q.ctrl <= CTRL_RST;
      s_q.sm <= ST_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  assign RDATA = s_q.rdata;
  assign COUNT_EN = s_q.cnt;
  assign COMP_RESULT = s_q.comp;
  assign QUALIFIER = s_q.qual;
endmodule : acr_context_top

`default_nettype wire

// ==== rtl/acr_pkg.sv ====
package acr_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int EA_W = 24;
  localparam int ST_W = 8;
  localparam int QM_DEPTH = 256;
  localparam int MASK_HI_BITS = 7;
  localparam int NCMP = 6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 10;
  localparam int PH4_NS = 80;
  localparam int PH5_NS = 160;
  localparam int TRES_NS = 160;
  localparam int ACQ_MIN_NS = 200;
  localparam int PH4_CYC = (PH4_NS + CLK_NS - 1) / CLK_NS;
  localparam int PH5_CYC = (PH5_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACQ_MIN_CYC = (ACQ_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [7:0] TRES_CYC = 8'(TRES_NS / CLK_NS);

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_BOUND_LAST = 8'h0e;
  localparam int BND_RANGE_BIT = 3;
  localparam int BND_SEL_BIT = 2;
  localparam logic [1:0] BND_HOLE = 2'h3;
  localparam logic [7:0] OFS_MASK = 8'h10;
  localparam logic [7:0] OFS_MODE = 8'h11;
  localparam logic [7:0] OFS_TEST = 8'h12;
  localparam logic [7:0] OFS_FORCE = 8'h13;
  localparam logic [7:0] OFS_QPTR = 8'h14;
  localparam logic [7:0] OFS_QDATA = 8'h15;
  localparam logic [7:0] OFS_CTRL = 8'h16;
  localparam logic [7:0] OFS_COMP_RD = 8'h17;
  localparam logic [7:0] OFS_CTX_RD = 8'h18;

  localparam int MASK_LSB_BIT = 0;
  localparam int MASK_HI_BIT = 1;
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_QSEL_LSB = 2;
  localparam int TEST_FORCE_BIT = 0;
  localparam int CTRL_RUN_BIT = 0;

  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {MD_OFF, MD_RANGE, MD_WINDOW, MD_SEQ} acr_mode_t;
  typedef enum logic [1:0] {ST_IDLE, ST_ACTIVE, ST_ARMED} acr_sm_t;

  typedef struct packed {
    logic [EA_W-1:0] addr;
    logic [ST_W-1:0] status;
  } acr_emu_t;

  typedef struct packed {
    logic event_en;
    logic time_en;
    logic seq_en;
  } acr_gate_t;

  typedef struct packed {
    logic [1:0][1:0][2:0][7:0] bound;
    logic [7:0] mask;
    logic [7:0] mode;
    logic [7:0] test;
    logic [7:0] force_bits;
    logic [7:0] ctrl;
    logic [7:0] qptr;
    logic [7:0] rdata;
    logic [QM_DEPTH-1:0][1:0] qmem;
    logic anal_q;
    logic [PH5_CYC-1:0] dline;
    acr_emu_t acq;
    logic [NCMP-1:0] comp;
    logic [1:0] qual;
    acr_sm_t sm;
    acr_gate_t sm_out;
    logic [7:0] tdiv;
    acr_gate_t cnt;
  } acr_state_t;
endpackage : acr_pkg

// ==== dv/acr_emu_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module acr_emu_model (
  input wire logic clk,
  output logic pin,
  output acr_pkg::acr_emu_t emu
);
  import acr_pkg::*;
  // ----------------------------------------
  // Emulation bus side
  // ----------------------------------------
  initial begin
    pin = 1'b0;
    emu = '0;
  end
  // One bus state per 20 cycles, the tightest spacing the pipeline takes
  task automatic step(input logic [EA_W-1:0] a, input logic [ST_W-1:0] s);
    @(posedge clk);
    pin <= 1'b1;
    emu <= '{a, s};
    @(posedge clk);
    // Bus valid only at the latch edge; scrambled so stale data cannot pass
    emu <= ~emu;
    repeat (8) @(posedge clk);
    pin <= 1'b0;
    repeat (10) @(posedge clk);
    @(negedge clk);
  endtask : step
endmodule : acr_emu_model
`default_nettype wire

// ==== dv/acr_context_props.sv ====
`timescale 1ns/1ns
`default_nettype none
module acr_context_props (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic [7:0] ADDR,
  input wire logic WR,
  input wire logic RD,
  input wire logic [7:0] RDATA,
  input wire logic ANALYSIS_CLOCK_N,
  input wire acr_pkg::acr_gate_t COUNT_EN,
  input wire logic [acr_pkg::NCMP-1:0] COMP_RESULT,
  input wire logic [1:0] QUALIFIER
);
  import acr_pkg::*;
  // ----------------------------------------
  // Bus and pipeline checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_rd_idle: assert property (
    !$past(RD) |-> RDATA == 8'h00) else $error("rdata not idle");
  chk_rd_comp: assert property (
    RD && ADDR == OFS_COMP_RD |=> RDATA == {2'b00, $past(COMP_RESULT)}) else $error("comp rd");
  chk_rd_ctx: assert property (
    RD && ADDR == OFS_CTX_RD |=> RDATA[7:6] == $past(QUALIFIER) && !RDATA[2]) else $error("ctx rd");
  chk_bound_hole: assert property (
    RD && ADDR[7:4] == 4'h0 && ADDR[1:0] == BND_HOLE ##1 1'b1 |-> RDATA == 8'h00)
    else $error("hole rd");
  // Results may only move at the phase-4 step; comparator results may also move right after any register write
  chk_comp_step: assert property (
    $changed(COMP_RESULT) |-> $past(WR) || $past(ANALYSIS_CLOCK_N, 9)
    && !$past(ANALYSIS_CLOCK_N, 10)) else $error("comp moved");
  chk_qual_step: assert property (
    $changed(QUALIFIER) |-> $past(ANALYSIS_CLOCK_N, 9) && !$past(ANALYSIS_CLOCK_N, 10))
    else $error("qual moved");
  chk_event_phase: assert property (
    COUNT_EN.event_en |-> $past(ANALYSIS_CLOCK_N, 17) && !$past(ANALYSIS_CLOCK_N, 18))
    else $error("event timing");
  chk_seq_phase: assert property (
    COUNT_EN.seq_en |-> $past(ANALYSIS_CLOCK_N, 17) && !$past(ANALYSIS_CLOCK_N, 18))
    else $error("seq timing");
  chk_time_base: assert property (
    COUNT_EN.time_en |=> !COUNT_EN.time_en [*8]) else $error("time base");
  cover property (COUNT_EN.event_en);
  cover property (COUNT_EN.seq_en);
  cover property (COUNT_EN.time_en);
  cover property (COMP_RESULT[1]);
endmodule : acr_context_props
bind acr_context_top acr_context_props u_props (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
  .WR(WR), .RD(RD), .RDATA(RDATA), .ANALYSIS_CLOCK_N(ANALYSIS_CLOCK_N), .COUNT_EN(COUNT_EN),
  .COMP_RESULT(COMP_RESULT), .QUALIFIER(QUALIFIER));
`default_nettype wire

// ==== dv/acr_context_top_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module acr_context_top_tb;
  import acr_pkg::*;
  logic clk, rst, wr, rd, pin;
  logic [7:0] addr, wdata, rdata;
  acr_emu_t emu;
  acr_gate_t cen;
  logic [NCMP-1:0] comp;
  logic [1:0] qual;
  int mismatches, samples_checked, n_ev, n_seq, n_tm;
  acr_context_top DUT (.REF_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .ANALYSIS_CLOCK_N(pin), .EMU(emu), .COUNT_EN(cen),
    .COMP_RESULT(comp), .QUALIFIER(qual));
  acr_emu_model emu_m (.clk(clk), .pin(pin), .emu(emu));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    n_ev += (cen.event_en === 1'b1);
    n_seq += (cen.seq_en === 1'b1);
    n_tm += (cen.time_en === 1'b1);
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata & m, e);
  endtask : rd_chk
  task automatic set_bound(input logic [7:0] base, input logic [23:0] v);
    for (int i = 0; i < 3; i++) wr_reg(base + 8'(i), v[8*i +: 8]);
  endtask : set_bound
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_ranges();
    logic [23:0] ad[7] = '{24'h000100, 24'h000120, 24'h000210, 24'h0000ff, 24'h000200,
      24'h800101, 24'h000121};
    logic [7:0] cp[7] = '{8'h06, 8'h03, 8'h10, 8'h00, 8'h30, 8'h02, 8'h03};
    logic [13:0] ms = 14'h1800;
    logic [6:0] ev = 7'b1100011;
    int e0;
    wr_reg(8'h03, 8'h5a);
    rd_chk(8'h03, 8'hff, 8'h00);
    set_bound(8'h00, 24'h000120);
    set_bound(8'h04, 24'h000100);
    set_bound(8'h08, 24'h000220);
    set_bound(8'h0c, 24'h000200);
    wr_reg(OFS_QPTR, 8'h5a);
    wr_reg(OFS_QDATA, 8'h02);
    wr_reg(OFS_QPTR, 8'h5a);
    rd_chk(OFS_QDATA, 8'h03, 8'h02);
    wr_reg(OFS_MODE, {6'h00, MD_RANGE});
    wr_reg(OFS_CTRL, 8'h01);
    for (int i = 0; i < 7; i++) begin
      wr_reg(OFS_MASK, {6'h00, ms[2*i +: 2]});
      e0 = n_ev;
      emu_m.step(ad[i], i == 0 ? 8'h5a : 8'h00);
      chk({2'b00, comp}, cp[i]);
      chk({6'h00, qual}, i == 0 ? 8'h02 : 8'h00);
      chk(8'(n_ev - e0), {7'h00, ev[i]});
    end
  endtask : t_ranges
  task automatic t_clear();
    int t0;
    emu_m.step(24'h000110, 8'h00);
    rd_chk(OFS_CTX_RD, 8'h30, 8'h30);
    wr_reg(OFS_MODE, {6'h00, MD_RANGE});
    rd_chk(OFS_CTX_RD, 8'h3f, 8'h00);
    t0 = n_tm;
    // Two and a half divider periods with the outputs cleared
    repeat (40) @(posedge clk);
    chk(8'(n_tm - t0), 8'h00);
  endtask : t_clear
  task automatic t_seq();
    int s0, e0, t0;
    wr_reg(OFS_MODE, {6'h00, MD_SEQ});
    s0 = n_seq;
    e0 = n_ev;
    t0 = n_tm;
    emu_m.step(24'h000100, 8'h00);
    emu_m.step(24'h000120, 8'h00);
    chk(8'(n_seq - s0), 8'h01);
    chk(8'(n_ev - e0), 8'h01);
    s0 = n_seq;
    emu_m.step(24'h000100, 8'h00);
    // Time gate opens at each step that finds the sequence armed and holds until the next one; the time output pulses once every 16 cycles while it is open
    chk({7'h00, n_tm > t0}, 8'h01);
    emu_m.step(24'h000210, 8'h00);
    emu_m.step(24'h000120, 8'h00);
    chk(8'(n_seq - s0), 8'h00);
  endtask : t_seq
  task automatic t_force();
    wr_reg(OFS_FORCE, 8'h2a);
    wr_reg(OFS_TEST, 8'h01);
    emu_m.step(24'h0000ff, 8'h00);
    rd_chk(OFS_COMP_RD, 8'h3f, 8'h2a);
    wr_reg(OFS_TEST, 8'h00);
    emu_m.step(24'h0000ff, 8'h00);
    rd_chk(OFS_COMP_RD, 8'h3f, 8'h00);
  endtask : t_force
  task automatic t_window();
    int e0;
    wr_reg(OFS_MODE, {4'h2, MD_WINDOW});
    e0 = n_ev;
    emu_m.step(24'h000100, 8'h5a);
    emu_m.step(24'h000000, 8'h00);
    emu_m.step(24'h000000, 8'h5a);
    emu_m.step(24'h000210, 8'h5a);
    chk(8'(n_ev - e0), 8'h02);
    rd_chk(OFS_CTX_RD, 8'hff, 8'h80);
    wr_reg(OFS_MODE, {6'h00, MD_OFF});
    e0 = n_ev;
    emu_m.step(24'h000100, 8'h5a);
    chk(8'(n_ev - e0), 8'h00);
  endtask : t_window
  task automatic t_hist();
    logic [23:0] lo[2] = '{24'h000100, 24'h000110};
    int e0, t0;
    wr_reg(OFS_MODE, {6'h00, MD_RANGE});
    for (int k = 0; k < 2; k++) begin
      set_bound(8'h00, lo[k] + 24'h00000f);
      set_bound(8'h04, lo[k]);
      e0 = n_ev;
      t0 = n_tm;
      emu_m.step(24'h000104, 8'h00);
      emu_m.step(24'h000118, 8'h00);
      emu_m.step(24'h00011a, 8'h00);
      chk(8'(n_ev - e0), 8'(k + 1));
      chk({7'h00, n_tm > t0}, 8'h01);
    end
  endtask : t_hist
  task automatic print_verdict();
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_chk(OFS_CTX_RD, 8'hff, 8'h00);
    t_ranges();
    t_clear();
    t_seq();
    t_force();
    t_window();
    t_hist();
    print_verdict();
  end
  // Run needs about 670 cycles
  initial begin
    #100000;
    mismatches++;
    print_verdict();
  end
endmodule : acr_context_top_tb
`default_nettype wire
